// ==== hdl/tmr_consts.svh ====
// Constants of the 8-bit timer with shared prescaler.
// Summary of operation
// R1 - 8-bit count, +1 per instruction cycle
// R2 - Source select zero means timer mode
// R3 - No counting two cycles after write
// R4 - Software may adjust loaded value
// R5 - Counter mode counts chosen input edge
// R6 - Source select one means counter mode
// R7 - Edge select one falling, zero rising
// R8 - External input synchronised by two samples
// R9 - One prescaler, timer or watchdog only
// R10 - Assign zero routes prescaler to timer
// R11 - Assign one routes prescaler to watchdog
// R12 - Timer ratios 1:2 to 1:256
// R13 - Codes double ratios; watchdog 1:1 to 1:128
// R14 - Timer 1:1 only when watchdog assigned
// R15 - Prescaler count not software accessible
// R16 - Count write clears prescaler when timer
// R17 - Watchdog clear clears prescaler when watchdog
// R18 - Software order for timer to watchdog
// R19 - Software order for watchdog to timer
// R20 - Wrap FFh to 00h sets flag
// R21 - Flag sets regardless of enable
// R22 - Only software clears the flag
// R23 - Request when flag and enable set
// R24 - Timer frozen during sleep
// R25 - Keeps counting after wrap from zero
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define TMR_COUNT_W      8
`define TMR_PRE_W        8
`define TMR_RATE_W       3
`define TMR_HOLD_CYCLES  2'h2
`define TMR_COUNT_RST    8'h00
`define TMR_COUNT_MAX    8'hFF
`define TMR_PRE_RST      8'h00
`endif

// ==== hdl/tmr_pkg.sv ====
// Types of the 8-bit timer with shared prescaler.
package tmr_pkg;
  typedef logic [7:0] count_t;
  typedef logic [2:0] rate_t;
endpackage : tmr_pkg

// ==== hdl/edge_sync.sv ====
// Two-stage synchroniser with selectable edge detect for the count input.
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  input  wire logic falling_in,
  output logic      edge_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic ev;
  } sync_s;
  sync_s st;
  sync_s next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.ev = falling_in ? (st.s3 & ~st.s2) : (~st.s3 & st.s2); // R7
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st; // R8
    end
  end

  assign edge_out = st.ev;

  s2_rise_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!falling_in && !st.s3 && st.s2) |=> edge_out) else $error("rising edge missed"); // R7
  s2_fall_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (falling_in && st.s3 && !st.s2) |=> edge_out) else $error("falling edge missed"); // R7
endmodule : edge_sync
`default_nettype wire

// ==== hdl/tmr_core.sv ====
// 8-bit timer/counter with prescaler shared with the watchdog.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.svh"
module tmr_core #(
  parameter int COUNT_W = `TMR_COUNT_W,
  parameter int PRE_W   = `TMR_PRE_W
) (
  input  wire logic           mclk_in,
  input  wire logic           rst_in,
  input  wire logic           ext_count_input_in,
  input  wire logic           clock_source_select_in,
  input  wire logic           source_edge_select_in,
  input  wire logic           prescaler_assign_in,
  input  wire tmr_pkg::rate_t rate_select_in,
  input  wire logic           overflow_irq_enable_in,
  input  wire logic           write_en_in,
  input  wire tmr_pkg::count_t write_data_in,
  input  wire logic           flag_clear_in,
  input  wire logic           watchdog_clear_instr_in,
  input  wire logic           sleep_in,
  input  wire logic           watchdog_tick_in,
  output var tmr_pkg::count_t timer_count_reg_out,
  output logic                overflow_flag_out,
  output logic                irq_out,
  output logic                watchdog_tick_out
);
  import tmr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    count_t           count;
    logic [PRE_W-1:0] pre; // R15
    logic [1:0]       hold;
    logic             flag;
    logic             irq;
    logic             wdt_tick;
  } core_s;

  core_s            st;
  core_s            next_st;
  logic             ext_edge;
  logic             src_tick;
  logic             pre_tap;
  logic             wdt_tap;
  logic [PRE_W-1:0] ones_run;

  edge_sync u_edge_sync (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .pin_in     (ext_count_input_in),
    .falling_in (source_edge_select_in),
    .edge_out   (ext_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler source and tap selection.

  // Carry chain: ones_run[i] is high when prescaler bits i down to 0 are all one.
  for (genvar gi = 0; gi < PRE_W; gi++) begin : g_run
    if (gi == 0) begin : g_lsb
      assign ones_run[gi] = st.pre[0];
    end else begin : g_up
      assign ones_run[gi] = ones_run[gi-1] & st.pre[gi];
    end
  end

  always_comb begin
    // Timer mode counts every cycle, counter mode counts synchronised edges.
    src_tick = clock_source_select_in ? ext_edge : 1'b1; // R2 R6 R5
    // Timer ratio 2^(code+1) needs code+1 low ones; watchdog 2^code needs code.
    pre_tap  = ones_run[rate_select_in]; // R12 R13
    wdt_tap  = (rate_select_in == 3'h0) ? 1'b1 : ones_run[rate_select_in - 3'h1]; // R13
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic [PRE_W:0] pre_inc;
    logic           timer_side_tick;
    logic           wdt_side_tick;
    pre_inc         = '0;
    timer_side_tick = 1'b0;
    wdt_side_tick   = 1'b0;
    next_st         = st;
    next_st.wdt_tick = 1'b0;
    if (!prescaler_assign_in) begin // R10 R9
      pre_inc = {1'b0, st.pre} + (PRE_W + 1)'(1);
      // One tick every 2^(rate+1) source events.
      timer_side_tick = src_tick && pre_tap; // R12
      if (src_tick) begin
        next_st.pre = pre_inc[PRE_W-1:0];
      end
      if (write_en_in) begin
        next_st.pre = PRE_W'(`TMR_PRE_RST); // R16
      end
      next_st.wdt_tick = watchdog_tick_in; // R14
    end else begin // R11 R14
      timer_side_tick = src_tick;
      if (watchdog_tick_in) begin
        next_st.pre = st.pre + PRE_W'(1);
      end
      wdt_side_tick = watchdog_tick_in && wdt_tap; // R13
      next_st.wdt_tick = wdt_side_tick;
      if (watchdog_clear_instr_in) begin
        next_st.pre = PRE_W'(`TMR_PRE_RST); // R17
      end
    end
    // Count update; the count never leaves the block except as an output.
    if (write_en_in) begin
      next_st.count = write_data_in;
      next_st.hold  = `TMR_HOLD_CYCLES; // R3
    end else if (st.hold != 2'h0) begin
      next_st.hold = st.hold - 2'h1; // R3
    end else if (timer_side_tick && !sleep_in) begin // R24
      next_st.count = st.count + 8'h01; // R1 R25
    end
    // Flag set wins over a software clear in the same cycle.
    if (flag_clear_in) begin
      next_st.flag = 1'b0; // R22
    end
    if (!write_en_in && st.hold == 2'h0 && timer_side_tick && !sleep_in &&
        st.count == `TMR_COUNT_MAX) begin
      next_st.flag = 1'b1; // R20 R21
    end
    next_st.irq = next_st.flag & overflow_irq_enable_in; // R23
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign timer_count_reg_out = st.count;
  assign overflow_flag_out   = st.flag;
  assign irq_out             = st.irq;
  assign watchdog_tick_out   = st.wdt_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  write_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (write_en_in ##1 !write_en_in [*2]) |-> $stable(st.count)) // R3
    else $error("count moved during hold");
  wrap_flag_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st.count == 8'hFF && !write_en_in ##1 st.count == 8'h00) |-> st.flag) // R20
    else $error("wrap without flag");
  flag_sticky_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st.flag && !flag_clear_in) |=> st.flag) // R22
    else $error("flag dropped by itself");
  irq_gate_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    irq_out |-> $past(overflow_irq_enable_in)) // R23
    else $error("request without enable");
  sleep_freeze_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (sleep_in && !write_en_in) |=> (st.count == $past(st.count))) // R24
    else $error("count moved in sleep");
  count_step_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!write_en_in) |=> (st.count == $past(st.count) ||
                        st.count == $past(st.count) + 8'h01)) // R1 R25
    else $error("count jumped");
  pre_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (write_en_in && !prescaler_assign_in) |=> st.pre == 8'h00) // R16
    else $error("prescaler not cleared on write");
  wdt_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (watchdog_clear_instr_in && prescaler_assign_in) |=> st.pre == 8'h00) // R17
    else $error("prescaler not cleared by watchdog clear");

  hold_load_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    write_en_in |=> (st.hold == `TMR_HOLD_CYCLES && st.count == $past(write_data_in))) // R3
    else $error("write not loaded");

  hold_block_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st.hold != 2'h0 && !write_en_in) |=> st.count == $past(st.count)) // R3
    else $error("count moved while held");

  irq_match_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    irq_out == (overflow_flag_out && $past(overflow_irq_enable_in))) // R23
    else $error("request not flag and enable");

  raw_wdt_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !prescaler_assign_in |=> watchdog_tick_out == $past(watchdog_tick_in)) // R10
    else $error("watchdog tick divided while timer owns prescaler");

  wdt_pass_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (prescaler_assign_in && rate_select_in == 3'h0) |=>
      watchdog_tick_out == $past(watchdog_tick_in)) // R13
    else $error("watchdog one to one ratio broken");

  wdt_quiet_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (prescaler_assign_in && !watchdog_tick_in) |=> !watchdog_tick_out) // R11
    else $error("watchdog tick without input");

  timer_one_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (prescaler_assign_in && !clock_source_select_in && !write_en_in &&
     st.hold == 2'h0 && !sleep_in) |=> st.count == $past(st.count) + 8'h01) // R14
    else $error("timer missed an undivided step");

  ext_step_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (prescaler_assign_in && clock_source_select_in && ext_edge && !write_en_in &&
     st.hold == 2'h0 && !sleep_in) |=> st.count == $past(st.count) + 8'h01) // R5
    else $error("external edge not counted");

  ext_idle_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (prescaler_assign_in && clock_source_select_in && !ext_edge && !write_en_in) |=>
      st.count == $past(st.count)) // R6
    else $error("counter moved without an edge");

  timer_div_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!prescaler_assign_in && !pre_tap && !write_en_in) |=> st.count == $past(st.count)) // R12
    else $error("count stepped between prescaler taps");

  flag_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (flag_clear_in && st.count != 8'hFF) |=> !st.flag) // R22
    else $error("flag not cleared");

  pre_timer_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!prescaler_assign_in && !write_en_in && !src_tick) |=> st.pre == $past(st.pre)) // R9
    else $error("prescaler moved without a timer source event");

  pre_wdt_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (prescaler_assign_in && !watchdog_tick_in && !watchdog_clear_instr_in) |=>
      st.pre == $past(st.pre)) // R9
    else $error("prescaler moved without a watchdog tick");

  wrap_seen_c: cover property (@(posedge mclk_in) st.count == 8'hFF ##1 st.count == 8'h00);
  hold_seen_c: cover property (@(posedge mclk_in) write_en_in ##1 st.hold == 2'h2);
  wdt_div_c: cover property (@(posedge mclk_in)
    prescaler_assign_in && rate_select_in == 3'h7 && watchdog_tick_out);
  irq_seen_c: cover property (@(posedge mclk_in) irq_out);
  ext_edge_c: cover property (@(posedge mclk_in) clock_source_select_in && ext_edge);
endmodule : tmr_core
`default_nettype wire

// ==== bench/cnt_src.sv ====
// Model of the signal source on the external count pin.
`timescale 1ns/1ps
`default_nettype none
module cnt_src (
  input  wire logic       mclk_in,
  input  wire logic       want_in,
  input  wire logic [1:0] lag_in,
  output logic            pin_out
);
  logic [1:0] wait_n;
  initial begin
    pin_out = 1'b0;
    wait_n  = 2'h0;
  end
  // The pin follows the request lag_in+1 cycles later, so prompt and slow sources both occur.
  always @(posedge mclk_in) begin
    if (want_in === pin_out) wait_n <= lag_in;
    else if (wait_n != 2'h0) wait_n <= wait_n - 2'h1;
    else pin_out <= want_in;
  end
endmodule : cnt_src
`default_nettype wire

// ==== bench/eight_bit_timer_shared_prescaler_bench.sv ====
// Self-checking bench of the 8-bit timer with shared prescaler.
`timescale 1ns/1ps
`default_nettype none
module eight_bit_timer_shared_prescaler_bench;
  import tmr_pkg::*;
  logic       mclk_in = 1'b0, rst_in = 1'b1, want = 1'b0, cs = 1'b0, es = 1'b0;
  logic       pa = 1'b1, ie = 1'b0, we = 1'b0, fc = 1'b0, wc = 1'b0, slp = 1'b0;
  logic       wt = 1'b0, pin, flag, irq, wto;
  logic [1:0] lag = 2'h0;
  rate_t      rs = 3'h0;
  count_t     wd = 8'h00, cnt, v;
  int         err_total = 0, samples_checked = 0, seed = 30995, n, off;
  always #5 mclk_in = ~mclk_in;
  cnt_src i_src (.mclk_in(mclk_in), .want_in(want), .lag_in(lag), .pin_out(pin));
  tmr_core i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .ext_count_input_in(pin),
    .clock_source_select_in(cs), .source_edge_select_in(es), .prescaler_assign_in(pa),
    .rate_select_in(rs), .overflow_irq_enable_in(ie), .write_en_in(we), .write_data_in(wd),
    .flag_clear_in(fc), .watchdog_clear_instr_in(wc), .sleep_in(slp),
    .watchdog_tick_in(wt), .timer_count_reg_out(cnt), .overflow_flag_out(flag),
    .irq_out(irq), .watchdog_tick_out(wto));
  ////////////////////////////////////////
  task automatic summarize;
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask : tick
  task automatic wr(input count_t d);
    wd = d;
    we = 1'b1;
    tick(1);
    we = 1'b0;
  endtask : wr
  task automatic wclr;
    wc = 1'b1;
    tick(1);
    wc = 1'b0;
  endtask : wclr
  // Moves the prescaler in the order that avoids a spurious watchdog expiry.
  task automatic swap(input logic a, input rate_t r);
    wclr();
    if (a) begin
      wr(8'h00);
      pa = 1'b1;
      wclr();
    end else pa = 1'b0;
    rs = r;
    tick(1);
  endtask : swap
  // Measures the cycles between two count steps, or between two watchdog output ticks.
  task automatic gap(input logic w, output int n);
    count_t c0;
    for (int p = 0; p < 2; p++) begin
      c0 = cnt;
      n = 0;
      do begin
        tick(1);
        n++;
      end while (n < 600 && (w ? wto !== 1'b1 : cnt === c0));
    end
    if (n >= 600) begin
      err_total++;
      summarize();
    end
  endtask : gap
  ////////////////////////////////////////
  initial begin
    tick(3);
    rst_in = 1'b0;
    chk({6'h00, cnt, flag, irq}, 16'h0000, "reset");
    v = 8'($random(seed)) & 8'h7F;
    wr(v);
    chk(cnt, v, "load");
    tick(2);
    chk(cnt, v, "hold");
    tick(1);
    chk(cnt, v + 8'h01, "step");
    wr(8'hFE);
    tick(5);
    chk(cnt, 8'h01, "wrap");
    chk({flag, irq}, 2'b10, "flag no irq");
    ie = 1'b1;
    tick(2);
    chk(irq, 1'b1, "irq");
    tick(20);
    chk(flag, 1'b1, "sticky");
    fc = 1'b1;
    tick(1);
    fc = 1'b0;
    tick(2);
    chk({flag, irq}, 2'b00, "cleared");
    slp = 1'b1;
    tick(1);
    v = cnt;
    tick(10);
    chk(cnt, v, "sleep");
    slp = 1'b0;
    wt = 1'b1;
    off = $random(seed);
    for (int c = 0; c < 8; c++) begin
      rs = rate_t'(c + off);
      swap(1'b0, rs);
      wr(8'h00);
      gap(1'b0, n);
      chk(16'(n), 16'h2 << rs, "timer ratio");
      gap(1'b1, n);
      chk(16'(n), 16'h1, "raw wd tick");
      swap(1'b1, rs);
      gap(1'b1, n);
      chk(16'(n), 16'h1 << rs, "wd ratio");
      gap(1'b0, n);
      chk(16'(n), 16'h1, "timer 1:1");
    end
    cs = 1'b1;
    for (int s = 0; s < 2; s++) begin
      es = s[0];
      lag = 2'($random(seed));
      wr(8'h00);
      want = 1'b1;
      tick(9);
      chk(cnt, {7'h00, ~es}, "rise");
      want = 1'b0;
      tick(9);
      chk(cnt, 8'h01, "fall");
    end
    summarize();
  end
endmodule : eight_bit_timer_shared_prescaler_bench
`default_nettype wire
